// [hw/etc_pkg.sv]
`default_nettype none
// shared constants and types for the elapsed-time serial clock
package etc_pkg;
	// system clock and power-up hold
	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned HOLD_MS       = 150;
	localparam int unsigned HOLD_CYC      = HOLD_MS * (CLK_HZ / 1000);
	localparam int unsigned HOLD_CW       = 22;

	// rates derived from the 400-cps timing pulse
	localparam int unsigned IN_CPS        = 400;
	localparam int unsigned GATE_CPS      = 2;
	localparam int unsigned SHIFT_CPS     = 50;
	localparam int unsigned GATE_DUTY_PCT = 80;
	localparam logic [7:0]  GATE_PERIOD   = 8'(IN_CPS / GATE_CPS);
	localparam logic [7:0]  GATE_HIGH     = 8'(IN_CPS / GATE_CPS * GATE_DUTY_PCT / 100);
	localparam logic [7:0]  SHIFT_MASK    = 8'(IN_CPS / SHIFT_CPS - 1);
	localparam logic [2:0]  SYM_LAST      = 3'(IN_CPS / SHIFT_CPS - 1);
	localparam logic [2:0]  SYM_HALF      = 3'(IN_CPS / SHIFT_CPS / 2);

	// word and buffer geometry
	localparam int          STAGES        = 20;
	localparam int          FIFO_DEPTH    = 8;

	// divider outputs that travel together
	typedef struct packed
	{
		logic gate;
		logic shift;
		logic first;
	} etc_div_s;

	// hold then run, gray along the path
	typedef enum logic [1:0]
	{
		ST_HOLD = 2'b00,
		ST_RUN  = 2'b01
	} etc_state_e;
endpackage
`default_nettype wire

// [hw/etc_fifo.sv]
`timescale 1ns/1ns
`default_nettype none
// small synchronous fifo with valid/ready on both sides
module etc_fifo #(
	parameter int W     = 1,
	parameter int DEPTH = 8
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0]   count;
	wire           push;
	wire           pop;

	// pointer step with wrap for any depth
	function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
		step = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	// handshake and flags
	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// storage write
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// pointers and fill level
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= step(wr_ptr);
			if (pop)
				rd_ptr <= step(rd_ptr);
			if (push & ~pop)
				count <= count + 1'b1;
			else if (pop & ~push)
				count <= count - 1'b1;
		end
	end
endmodule
`default_nettype wire

// [hw/etc_time_clock.sv]
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - count half-seconds since power, 2^20 capacity
// - one serial 20-bit gray word per half-second
// - time word leads each telemetry frame
// - hold divider, register, mode cleared ~150 ms
// - divide to 2-cps 80% gate, 50-cps pulses
// - twenty shift pulses per 400 ms envelope
// - gate also routed to GATE_2CPS output
// - 20-stage register counts and shifts out
// - last stage feeds first, optional inversion
// - mode flip-flop enables or stops inversion
// - formatter turns nrz stream into rz
// - one is high level, zero is low
module etc_time_clock #(
	parameter int unsigned HOLD_CYCLES = etc_pkg::HOLD_CYC,
	parameter int          STAGES      = etc_pkg::STAGES,
	parameter int          DEPTH       = etc_pkg::FIFO_DEPTH
) (
	input  wire logic CLK,
	input  wire logic SYS_RST,
	input  wire logic PULSE_400,
	output logic      SER_OUT,
	output logic      GATE_2CPS,
	output logic      HOLD
);
	import etc_pkg::*;

	etc_state_e        state;
	etc_state_e        next_state;
	logic [HOLD_CW-1:0] hold_cnt;
	logic [7:0]        phase;
	logic [STAGES-1:0] sreg;
	logic [STAGES-1:0] word;
	logic              mode;
	logic              pend_v;
	logic              pend_bit;
	logic              sym_act;
	logic              sym_bit;
	logic [2:0]        sym_tick;
	logic [4:0]        shift_cnt;
	logic [STAGES-1:0] prev_count;
	etc_div_s          div;
	wire               running;
	wire               tick;
	wire               hold_done;
	wire               clr;
	wire               eff_mode;
	wire               out_bit;
	wire               in_bit;
	wire               next_mode;
	wire [STAGES-1:0]  count_bin;
	wire [STAGES-1:0]  gray_now;
	wire [STAGES-1:0]  gray_prev;
	wire               fifo_in_ready;
	wire               fifo_out_v;
	wire [0:0]         fifo_out_d;
	wire               fmt_ready;
	wire               next_ser;

	// register stage order to binary value, stage 20 is the lsb
	function automatic logic [STAGES-1:0] to_bin(input logic [STAGES-1:0] r);
		for (int i = 0; i < STAGES; i++)
			to_bin[i] = r[STAGES-1-i];
	endfunction

	// binary to reflected gray
	function automatic logic [STAGES-1:0] to_gray(input logic [STAGES-1:0] b);
		to_gray = b ^ (b >> 1);
	endfunction

	// run state and tick qualification
	assign running   = (state == ST_RUN);
	assign tick      = running & PULSE_400;
	assign hold_done = (hold_cnt == HOLD_CW'(HOLD_CYCLES - 1));
	assign clr       = SYS_RST | ~running;

	// hold then run sequencing
	always_comb
	begin
		case (state)
			ST_HOLD: next_state = hold_done ? ST_RUN : ST_HOLD;
			ST_RUN:  next_state = ST_RUN;
			default: next_state = ST_HOLD;
		endcase
	end

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			state <= ST_HOLD;
		else
			state <= next_state;
	end

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			hold_cnt <= '0;
		else if ((state == ST_HOLD) && !hold_done)
			hold_cnt <= hold_cnt + 1'b1;
	end

	assign div.gate  = running & (phase < GATE_HIGH);
	assign div.shift = tick & div.gate & ((phase & SHIFT_MASK) == 8'h00);
	assign div.first = div.shift & (phase == 8'h00);

	// divide by 200 on the timing pulse
	always_ff @(posedge CLK)
	begin
		if (clr)
			phase <= 8'h00;
		else if (tick)
			phase <= (phase == GATE_PERIOD - 8'h01) ? 8'h00 : phase + 8'h01;
	end

	assign out_bit   = sreg[STAGES-1];
	assign eff_mode  = div.first | mode;
	assign in_bit    = eff_mode ? ~out_bit : out_bit;
	// stop inverting after a zero passes
	assign next_mode = eff_mode & out_bit;
	assign count_bin = to_bin(sreg);
	assign gray_now  = to_gray(count_bin);
	assign gray_prev = to_gray(prev_count);

	// burst register shifts on each shift pulse
	always_ff @(posedge CLK)
	begin
		if (clr)
			sreg <= '0;
		else if (div.shift)
			sreg <= {sreg[STAGES-2:0], in_bit};
	end

	always_ff @(posedge CLK)
	begin
		if (clr)
			mode <= 1'b0;
		else if (div.shift)
			mode <= next_mode;
	end

	// snapshot gray word, send msb first
	always_ff @(posedge CLK)
	begin
		if (clr)
		begin
			word     <= '0;
			pend_bit <= 1'b0;
		end
		else if (div.first)
		begin
			word     <= gray_now << 1;
			pend_bit <= gray_now[STAGES-1];
		end
		else if (div.shift)
		begin
			word     <= word << 1;
			pend_bit <= word[STAGES-1];
		end
	end

	// pending bit waits for fifo space
	always_ff @(posedge CLK)
	begin
		if (clr)
			pend_v <= 1'b0;
		else if (div.shift)
			pend_v <= 1'b1;
		else if (fifo_in_ready)
			pend_v <= 1'b0;
	end

	// bit buffer between register and formatter
	etc_fifo #(
		.W     (1),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (CLK),
		.rst       (clr),
		.in_valid  (pend_v),
		.in_ready  (fifo_in_ready),
		.in_data   (pend_bit),
		.out_valid (fifo_out_v),
		.out_ready (fmt_ready),
		.out_data  (fifo_out_d)
	);

	// formatter takes one bit per symbol
	assign fmt_ready = running & ~sym_act;

	always_ff @(posedge CLK)
	begin
		if (clr)
		begin
			sym_act  <= 1'b0;
			sym_bit  <= 1'b0;
			sym_tick <= 3'h0;
		end
		else if (fmt_ready & fifo_out_v)
		begin
			sym_act  <= 1'b1;
			sym_bit  <= fifo_out_d[0];
			sym_tick <= 3'h0;
		end
		else if (sym_act & tick)
		begin
			if (sym_tick == SYM_LAST)
				sym_act <= 1'b0;
			sym_tick <= sym_tick + 3'h1;
		end
	end

	// high for first half of symbol
	assign next_ser = sym_act & sym_bit & (sym_tick < SYM_HALF);

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			SER_OUT   <= 1'b0;
			GATE_2CPS <= 1'b0;
			HOLD      <= 1'b1;
		end
		else
		begin
			SER_OUT   <= next_ser;
			GATE_2CPS <= div.gate;
			HOLD      <= ~running;
		end
	end

	// checking helpers: shifts per gate and count before burst
	always_ff @(posedge CLK)
	begin
		if (clr)
		begin
			shift_cnt  <= 5'h00;
			prev_count <= '0;
		end
		else if (div.first)
		begin
			shift_cnt  <= 5'h01;
			prev_count <= count_bin;
		end
		else if (div.shift)
			shift_cnt <= shift_cnt + 5'h01;
	end

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);

	property p_hold_clear;
		(state == ST_HOLD) |-> (phase == 8'h00) && (sreg == '0) && !mode && HOLD;
	endproperty
	a_hold_clear: assert property (p_hold_clear)
		else $error("registers not held clear during power-up hold");

	property p_hold_len;
		$rose(running) |-> (hold_cnt == HOLD_CW'(HOLD_CYCLES - 1));
	endproperty
	a_hold_len: assert property (p_hold_len)
		else $error("hold released at wrong count");

	property p_gate_fall;
		(tick && (phase == GATE_HIGH - 8'h01)) |=> !div.gate ##1 !GATE_2CPS;
	endproperty
	a_gate_fall: assert property (p_gate_fall)
		else $error("gate did not end after 160 ticks");

	property p_gate_wrap;
		(tick && (phase == GATE_PERIOD - 8'h01)) |=> (phase == 8'h00) && div.gate;
	endproperty
	a_gate_wrap: assert property (p_gate_wrap)
		else $error("divider period not 200 ticks");

	property p_twenty;
		$fell(div.gate) && running |-> (shift_cnt == 5'(STAGES));
	endproperty
	a_twenty: assert property (p_twenty)
		else $error("burst did not hold twenty shifts");

	property p_advance;
		$fell(div.gate) && running |-> (count_bin == STAGES'(prev_count + 1'b1));
	endproperty
	a_advance: assert property (p_advance)
		else $error("burst did not advance count by one");

	property p_mode_stop;
		(div.shift && eff_mode && !out_bit) |=> !mode;
	endproperty
	a_mode_stop: assert property (p_mode_stop)
		else $error("inversion not stopped after a zero");

	property p_snap;
		div.first |=> pend_v && (pend_bit == gray_prev[STAGES-1]);
	endproperty
	a_snap: assert property (p_snap)
		else $error("first serial bit is not gray msb");

	property p_rz_one;
		(fmt_ready && fifo_out_v && fifo_out_d[0]) |-> ##2 SER_OUT;
	endproperty
	a_rz_one: assert property (p_rz_one)
		else $error("one bit did not drive high level");

	property p_rz_return;
		(sym_act && (sym_tick >= SYM_HALF)) |=> !SER_OUT;
	endproperty
	a_rz_return: assert property (p_rz_return)
		else $error("output not returned in second half");

	property p_no_overrun;
		(div.shift && !div.first) |-> !pend_v || fifo_in_ready;
	endproperty
	a_no_overrun: assert property (p_no_overrun)
		else $error("serial bit lost before buffering");

	c_wrap: cover property ($fell(div.gate) && running && (prev_count == '1));
	c_one_sent: cover property ($rose(SER_OUT));
	c_burst: cover property ($fell(div.gate) && running && (shift_cnt == 5'(STAGES)));
endmodule
`default_nettype wire

// [verification/etc_frame_rx.sv]
`timescale 1ns/1ns
`default_nettype none
// telemetry side: decodes rz time words framed by the gate
module etc_frame_rx (
	input  wire logic   clk,
	input  wire logic   rst,
	input  wire logic   ser,
	input  wire logic   gate,
	output logic        word_valid,
	output logic [19:0] word,
	output logic [11:0] gate_len,
	output logic        rz_bad
);
	logic        gate_d;
	logic        ser_d;
	logic [11:0] off;
	logic [7:0]  run;
	logic [4:0]  idx;

	// symbol slot of 64 cycles, offset past the output latency
	assign idx = 5'((off - 12'h004) >> 6);

	always_ff @(posedge clk)
	begin
		word_valid <= 1'b0;
		rz_bad     <= 1'b0;
		gate_d     <= gate;
		ser_d      <= ser;
		if (rst)
		begin
			gate_d <= 1'b0;
			ser_d  <= 1'b0;
			off    <= 12'h000;
			run    <= 8'h00;
		end
		else
		begin
			if (gate && !gate_d)
				off <= 12'h001;
			else if (gate)
				off <= off + 12'h001;
			if (gate && !gate_d)
				word <= 20'h00000;
			else if (gate && off >= 12'h004 && idx < 5'd20 && ser)
				word[5'd19 - idx] <= 1'b1;
			if (!gate && gate_d)
				word_valid <= 1'b1;
			if (!gate && gate_d)
				gate_len <= off;
			if (ser)
				run <= run + 8'h01;
			else
				run <= 8'h00;
			if (!ser && ser_d && (run < 8'd26 || run > 8'd36))
				rz_bad <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// [verification/tb_etc_time_clock.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_etc_time_clock;
	import etc_pkg::*;
	localparam int P = 8; // clk cycles between timing ticks
	localparam int HC = 16; // short power-up hold for simulation

	logic        CLK = 1'b0;
	logic        SYS_RST = 1'b1;
	logic        PULSE_400 = 1'b0;
	logic        SER_OUT;
	logic        GATE_2CPS;
	logic        HOLD;
	logic        wv;
	logic        rzb;
	logic [19:0] w;
	logic [11:0] glen;
	logic [7:0]  lfsr = 8'h39;
	logic        run_ticks = 1'b0;
	logic [19:0] expq[$];
	int          failures = 0;
	int          tests_run = 0;
	int          cyc = 0;
	int          t0 = 0;
	int          seen = 0;

	etc_time_clock #(.HOLD_CYCLES(HC)) dut (
		.CLK       (CLK),
		.SYS_RST   (SYS_RST),
		.PULSE_400 (PULSE_400),
		.SER_OUT   (SER_OUT),
		.GATE_2CPS (GATE_2CPS),
		.HOLD      (HOLD)
	);

	etc_frame_rx rx (
		.clk        (CLK),
		.rst        (SYS_RST),
		.ser        (SER_OUT),
		.gate       (GATE_2CPS),
		.word_valid (wv),
		.word       (w),
		.gate_len   (glen),
		.rz_bad     (rzb)
	);

	initial
	begin
		forever #25 CLK = ~CLK;
	end

	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic check(input string what, input logic [19:0] exp, input logic [19:0] act);
		tests_run++;
		if (act !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, act);
		end
	endtask

	task automatic test_done;
		$display("counts: %0d compared, %0d mismatched", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ticks every P cycles, first one P cycles into run; noise in hold
	always @(posedge CLK)
	begin
		cyc <= cyc + 1;
		lfsr <= lfsr_next(lfsr);
		PULSE_400 <= run_ticks ? ((cyc - t0) % P == 0) : lfsr[0];
	end

	// compare each decoded word with the oldest expectation
	always @(posedge CLK)
	begin
		if (wv === 1'b1)
		begin
			seen <= seen + 1;
			check("time word", (expq.size() > 0) ? expq.pop_front() : 20'hxxxxx, w);
			check("gate high cycles", 20'(int'(GATE_HIGH) * P), 20'(glen));
		end
		if (rzb === 1'b1)
			check("rz pulse width", 20'h00000, 20'h00001);
		if (cyc == 40000)
		begin
			failures++;
			test_done();
		end
	end

	// reset, note the gray words expected from zero, check the hold
	task automatic do_reset(input int words);
		int i;
		@(posedge CLK);
		SYS_RST <= 1'b1;
		run_ticks <= 1'b0;
		repeat (16) @(posedge CLK);
		expq.delete();
		for (i = 0; i < words + 2; i++)
			expq.push_back(20'(i ^ (i >> 1)));
		SYS_RST <= 1'b0;
		// first accepted tick lands P cycles after the run state starts
		t0 <= cyc + HC + P - 1;
		repeat (8) @(posedge CLK);
		run_ticks <= 1'b1;
		repeat (2) @(negedge CLK);
		check("hold flag", 20'h00001, 20'(HOLD));
		check("gate in hold", 20'h00000, 20'(GATE_2CPS));
		check("serial in hold", 20'h00000, 20'(SER_OUT));
		repeat (20) @(negedge CLK);
		check("hold released", 20'h00000, 20'(HOLD));
	endtask

	task automatic wait_words(input int n);
		int k;
		for (k = 0; k < 12000 && seen < n; k++)
			@(posedge CLK);
		check("words seen", 20'(n), 20'(seen));
	endtask

	initial
	begin
		int k;
		do_reset(4);
		wait_words(4);
		$display("test counting from power-up done");
		for (k = 0; k < 2000 && GATE_2CPS !== 1'b1; k++)
			@(posedge CLK);
		repeat (700) @(posedge CLK);
		do_reset(2);
		wait_words(6);
		$display("test reset in mid-burst done");
		test_done();
	end
endmodule
`default_nettype wire
